// ==== hdl/sld_pkg.sv ====
// shared constants and types for the speculative load deferral unit
package sld_pkg;

  // exception condition indices, highest fault priority first
  localparam int SLD_NCOND     = 14;
  localparam int SLD_REG_TOKEN = 0;
  localparam int SLD_UNIMPL    = 1;
  localparam int SLD_ALT_MISS  = 2;
  localparam int SLD_HPW_DATA  = 3;
  localparam int SLD_DTLB_MISS = 4;
  localparam int SLD_NOT_PRES  = 5;
  localparam int SLD_DEF_PAGE  = 6;
  localparam int SLD_KEY_MISS  = 7;
  localparam int SLD_KEY_PERM  = 8;
  localparam int SLD_ACC_RGHT  = 9;
  localparam int SLD_ACC_BIT   = 10;
  localparam int SLD_DBG       = 11;
  localparam int SLD_UNALIGN   = 12;
  localparam int SLD_UNSUPP    = 13;

  typedef logic [SLD_NCOND-1:0] sld_cond_t;

  // concurrent conditions that preclude each condition
  localparam sld_cond_t SLD_PRECL [SLD_NCOND] = '{
    14'h0000, 14'h0001, 14'h0003, 14'h0003, 14'h0003, 14'h001f,
    14'h003f, 14'h003f, 14'h00bf, 14'h003f, 14'h003f, 14'h0003,
    14'h0003, 14'h003f};
  // conditions deferred for any control setting
  localparam sld_cond_t SLD_ALWAYS = 14'h2043;

  // register map, byte addresses
  localparam logic [7:0] SLD_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SLD_STAT_ADDR = 8'h04;
  localparam logic [7:0] SLD_CNT_ADDR  = 8'h08;
  localparam logic [7:0] SLD_CTRL_RST  = 8'h00;

  // control field positions (default control bits + spontaneous)
  localparam int SLD_F_TLB   = 0;
  localparam int SLD_F_NP    = 1;
  localparam int SLD_F_KMISS = 2;
  localparam int SLD_F_KPERM = 3;
  localparam int SLD_F_RGHT  = 4;
  localparam int SLD_F_ABIT  = 5;
  localparam int SLD_F_DBG   = 6;
  localparam int SLD_F_SPONT = 7;
  // status field positions
  localparam int SLD_S_SPEC  = 0;
  localparam int SLD_S_CAPT  = 1;
  localparam int SLD_S_CODE  = 4;

  typedef struct packed {
    logic      valid;
    logic      spec;
    logic      intrCollect;
    logic      instrXlate;
    logic      forceDefer;
    logic      codePageDefer;
    logic      uncacheable;
    logic      limitedSpec;
    logic      implDep;
    sld_cond_t cond;
  } sld_req_s;

  typedef struct packed {
    logic       valid;
    logic       writeToken;
    logic       fault;
    logic [3:0] faultIdx;
    logic       suppressMem;
    logic       sideEffects;
    logic       writeData;
  } sld_rsp_s;

endpackage

// ==== hdl/sld_defer_unit.sv ====
// deferral decision, fault selection and syndrome capture for loads
//////////////////////////////////////////////////////////////////////
// Functional notes
// - Deferral looks only at conditions left after preclusion.
// - Interruption collection off defers every data reference condition.
// - Unimplemented address and deferral page consumption always defer.
// - Recovery model plus matching control enable defers the condition.
// - Recovery model defers unaligned references without any enable.
// - Translation miss classes use the TLB miss enable.
// - Not present and key miss use their own enables.
// - Key permission and access rights use their own enables.
// - Access bit and data debug use their own enables.
// - Token address and unsupported references always defer.
// - Implementation conditions defer only in recovery with spontaneous on.
// - Force bit on a speculative load writes the token regardless of all else.
// - Otherwise highest priority remaining condition raises its fault.
// - Deferred conditions take no part in prioritization.
// - All conditions precluded or deferred gives token, no fault.
// - Clean speculative load to uncacheable or limited page gives token.
// - Clean load may get token through permitted spontaneous deferral.
// - Otherwise the load completes and writes its data.
// - Interruption records whether the load was speculative.
// - Interruption captures the code page deferral bit.
// - Deferred loads keep side effects but suppress memory access.
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module sld_defer_unit
  import sld_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // load pipeline
  input  wire sld_req_s    loadReq,
  output sld_rsp_s         loadRsp
);

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrl_r;
  logic        specLoadFlag_r;
  logic        capturedDefer_r;
  logic [3:0]  lastFault_r;
  logic [31:0] deferCnt_r;

  //////////////////////////////////////////////////////////////////////
  // qualification
  sld_cond_t qual;

  genvar gi;
  generate
    for (gi = 0; gi < SLD_NCOND; gi++) begin : g_qual
      assign qual[gi] = loadReq.cond[gi]
                      & ~|(loadReq.cond & SLD_PRECL[gi]);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // deferral
  logic      recovery;
  logic      spontDefer;
  sld_cond_t ctrlEn;
  sld_cond_t deferMask;
  sld_cond_t remain;

  assign recovery = loadReq.instrXlate & loadReq.codePageDefer;

  always_comb begin
    ctrlEn = '0;
    ctrlEn[SLD_ALT_MISS] = ctrl_r[SLD_F_TLB];
    ctrlEn[SLD_HPW_DATA] = ctrl_r[SLD_F_TLB];
    ctrlEn[SLD_DTLB_MISS] = ctrl_r[SLD_F_TLB];
    ctrlEn[SLD_NOT_PRES] = ctrl_r[SLD_F_NP];
    ctrlEn[SLD_KEY_MISS] = ctrl_r[SLD_F_KMISS];
    ctrlEn[SLD_KEY_PERM] = ctrl_r[SLD_F_KPERM];
    ctrlEn[SLD_ACC_RGHT] = ctrl_r[SLD_F_RGHT];
    ctrlEn[SLD_ACC_BIT] = ctrl_r[SLD_F_ABIT];
    ctrlEn[SLD_DBG] = ctrl_r[SLD_F_DBG];
    ctrlEn[SLD_UNALIGN] = 1'b1;
  end

  always_comb begin
    deferMask = SLD_ALWAYS;
    if (!loadReq.intrCollect) begin
      deferMask = '1;
    end else if (recovery) begin
      deferMask = SLD_ALWAYS | ctrlEn;
    end
    // plain loads never defer
    if (!loadReq.spec) begin
      deferMask = '0;
    end
  end

  assign remain = qual & ~deferMask;
  assign spontDefer = loadReq.spec & loadReq.implDep
                    & loadReq.intrCollect & recovery
                    & ctrl_r[SLD_F_SPONT];

  //////////////////////////////////////////////////////////////////////
  // outcome, same cycle as qualification
  logic       dToken;
  logic       dFault;
  logic [3:0] dIdx;

  always_comb begin
    dIdx = '0;
    for (int i = SLD_NCOND - 1; i >= 0; i--) begin
      if (remain[i]) begin
        dIdx = 4'(i);
      end
    end
  end

  always_comb begin
    dToken = 1'b0;
    dFault = 1'b0;
    if (loadReq.spec && loadReq.forceDefer) begin
      dToken = 1'b1;
    end else if (|remain) begin
      dFault = 1'b1;
    end else if (loadReq.spec && |qual) begin
      dToken = 1'b1;
    end else if (loadReq.spec
                 && (loadReq.uncacheable || loadReq.limitedSpec)) begin
      dToken = 1'b1;
    end else if (spontDefer) begin
      dToken = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadRsp <= '0;
    end else begin
      loadRsp.valid <= loadReq.valid;
      loadRsp.writeToken <= loadReq.valid & dToken;
      loadRsp.fault <= loadReq.valid & dFault;
      loadRsp.faultIdx <= (loadReq.valid && dFault) ? dIdx : 4'h0;
      // token suppresses the reference, not the base update
      loadRsp.suppressMem <= loadReq.valid & (dToken | dFault);
      loadRsp.sideEffects <= loadReq.valid & ~dFault;
      loadRsp.writeData <= loadReq.valid & ~dToken & ~dFault;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interruption syndrome
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      specLoadFlag_r <= 1'b0;
      capturedDefer_r <= 1'b0;
      lastFault_r <= 4'h0;
    end else if (loadReq.valid && dFault) begin
      specLoadFlag_r <= loadReq.spec;
      capturedDefer_r <= loadReq.codePageDefer;
      lastFault_r <= dIdx;
    end
  end

  // wraps silently; software reads differences
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deferCnt_r <= '0;
    end else if (loadReq.valid && dToken) begin
      deferCnt_r <= deferCnt_r + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave, zero wait: answer prepared in the setup cycle
  logic setup;
  logic mapped;
  logic wrEn;

  assign setup = psel & ~penable;
  assign mapped = (paddr == SLD_CTRL_ADDR) || (paddr == SLD_STAT_ADDR)
               || (paddr == SLD_CNT_ADDR);
  assign wrEn = psel & penable & pready & pwrite;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= SLD_CTRL_RST;
    end else if (wrEn && paddr == SLD_CTRL_ADDR) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= '0;
      if (setup && !pwrite) begin
        unique case (paddr)
          SLD_CTRL_ADDR: prdata <= {24'h0, ctrl_r};
          SLD_STAT_ADDR: begin
            prdata[SLD_S_SPEC] <= specLoadFlag_r;
            prdata[SLD_S_CAPT] <= capturedDefer_r;
            prdata[SLD_S_CODE +: 4] <= lastFault_r;
          end
          SLD_CNT_ADDR: prdata <= deferCnt_r;
          default: prdata <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_force;
    loadReq.valid && loadReq.spec && loadReq.forceDefer
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_force: assert property (p_force)
    else $error("force bit did not give token");

  property p_nocollect;
    loadReq.valid && loadReq.spec && !loadReq.intrCollect
      |=> !loadRsp.fault;
  endproperty
  a_nocollect: assert property (p_nocollect)
    else $error("fault with collection off");

  property p_always;
    loadReq.valid && loadReq.spec && !loadReq.forceDefer
      && loadReq.cond != '0 && (loadReq.cond & ~SLD_ALWAYS) == '0
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_always: assert property (p_always)
    else $error("always-deferred condition faulted");

  property p_prio;
    loadRsp.fault |-> (($past(remain) >> loadRsp.faultIdx) & 14'h1) != '0
      && ($past(remain) & ((14'h1 << loadRsp.faultIdx) - 14'h1)) == '0;
  endproperty
  a_prio: assert property (p_prio)
    else $error("fault index not a live condition");

  property p_syndrome;
    loadReq.valid && dFault
      |=> specLoadFlag_r == $past(loadReq.spec)
      && capturedDefer_r == $past(loadReq.codePageDefer);
  endproperty
  a_syndrome: assert property (p_syndrome)
    else $error("syndrome not captured");

  property p_uncached;
    loadReq.valid && loadReq.spec && !loadReq.forceDefer
      && loadReq.cond == '0 && loadReq.uncacheable
      |=> loadRsp.writeToken;
  endproperty
  a_uncached: assert property (p_uncached)
    else $error("uncacheable clean load not deferred");

  property p_normal;
    loadReq.valid && !loadReq.forceDefer && loadReq.cond == '0
      && !loadReq.uncacheable && !loadReq.limitedSpec
      && !loadReq.implDep
      |=> loadRsp.writeData && !loadRsp.suppressMem;
  endproperty
  a_normal: assert property (p_normal)
    else $error("clean load did not complete");

  property p_side;
    loadRsp.writeToken |-> loadRsp.sideEffects && loadRsp.suppressMem
      && !loadRsp.writeData;
  endproperty
  a_side: assert property (p_side)
    else $error("deferred load effects wrong");

  property p_unalign;
    loadReq.valid && loadReq.spec && !loadReq.forceDefer
      && loadReq.intrCollect && recovery
      && loadReq.cond == (sld_cond_t'(1) << SLD_UNALIGN)
      |=> loadRsp.writeToken;
  endproperty
  a_unalign: assert property (p_unalign)
    else $error("unaligned not deferred in recovery");

  property p_apb;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb answer timing wrong");

  // valid unforced speculative request, shared by the next seven checks
  logic specReq;
  assign specReq = loadReq.valid & loadReq.spec & ~loadReq.forceDefer;

  property p_tlbmiss;
    specReq && loadReq.intrCollect && recovery && ctrl_r[SLD_F_TLB]
      && loadReq.cond == (sld_cond_t'(1) << SLD_DTLB_MISS)
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_tlbmiss: assert property (p_tlbmiss)
    else $error("tlb miss not deferred with enable");

  property p_notpres;
    specReq && loadReq.intrCollect && recovery && ctrl_r[SLD_F_NP]
      && loadReq.cond == (sld_cond_t'(1) << SLD_NOT_PRES)
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_notpres: assert property (p_notpres)
    else $error("not present not deferred with enable");

  property p_keyperm;
    specReq && loadReq.intrCollect && recovery && ctrl_r[SLD_F_KPERM]
      && loadReq.cond == (sld_cond_t'(1) << SLD_KEY_PERM)
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_keyperm: assert property (p_keyperm)
    else $error("key permission not deferred with enable");

  property p_accbit;
    specReq && loadReq.intrCollect && recovery && ctrl_r[SLD_F_ABIT]
      && loadReq.cond == (sld_cond_t'(1) << SLD_ACC_BIT)
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_accbit: assert property (p_accbit)
    else $error("access bit not deferred with enable");

  property p_norecov;
    specReq && loadReq.intrCollect && !recovery
      && loadReq.cond == (sld_cond_t'(1) << SLD_ACC_BIT)
      |=> loadRsp.fault && loadRsp.faultIdx == 4'(SLD_ACC_BIT);
  endproperty
  a_norecov: assert property (p_norecov)
    else $error("enable applied outside recovery model");

  property p_precl;
    specReq && loadReq.intrCollect && !recovery
      && loadReq.cond == ((sld_cond_t'(1) << SLD_UNIMPL)
                         | (sld_cond_t'(1) << SLD_DTLB_MISS))
      |=> loadRsp.writeToken && !loadRsp.fault;
  endproperty
  a_precl: assert property (p_precl)
    else $error("precluded condition raised a fault");

  property p_spont;
    specReq && loadReq.cond == '0 && loadReq.implDep
      && !loadReq.uncacheable && !loadReq.limitedSpec
      && !(loadReq.intrCollect && recovery && ctrl_r[SLD_F_SPONT])
      |=> loadRsp.writeData && !loadRsp.writeToken;
  endproperty
  a_spont: assert property (p_spont)
    else $error("spontaneous deferral outside recovery");

  property p_faultfx;
    loadRsp.fault |-> loadRsp.suppressMem && !loadRsp.sideEffects
      && !loadRsp.writeToken && !loadRsp.writeData;
  endproperty
  a_faultfx: assert property (p_faultfx)
    else $error("faulting load effects wrong");

  property p_count;
    loadRsp.writeToken |-> deferCnt_r == $past(deferCnt_r) + 32'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("token counter did not advance");

  property p_pslverr;
    setup && paddr != SLD_CTRL_ADDR && paddr != SLD_STAT_ADDR
      && paddr != SLD_CNT_ADDR |=> pready && pslverr && prdata == '0;
  endproperty
  a_pslverr: assert property (p_pslverr)
    else $error("unmapped access not refused");

endmodule

// ==== tb/sld_pipe_model.sv ====
// load pipeline stand-in: issues loads and collects the unit's answers
`timescale 1ns/1ps

module sld_pipe_model
  import sld_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     reset_n,
  // bench side
  input  wire logic     go,
  input  wire sld_req_s nextReq,
  output sld_rsp_s      lastRsp,
  output logic [7:0]    nRsp,
  // unit side
  output sld_req_s      loadReq,
  input  wire sld_rsp_s loadRsp
);
  // idle fields flip each cycle so a stale descriptor never looks valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadReq <= '0;
    end else if (go) begin
      loadReq <= nextReq;
    end else begin
      loadReq <= {1'b0, ~loadReq[$bits(sld_req_s)-2:0]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastRsp <= '0;
      nRsp    <= 8'h00;
    end else if (loadRsp.valid) begin
      lastRsp <= loadRsp;
      nRsp    <= nRsp + 8'h01;
    end
  end
endmodule

// ==== tb/sld_defer_unit_tb.sv ====
// self-checking bench for the speculative load deferral unit
`timescale 1ns/1ps

module sld_defer_unit_tb
  import sld_pkg::*;
();
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  fl;
    logic [13:0] cond;
    logic [5:0]  res;
  } sld_row_s;

  logic        clk, reset_n, psel, penable, pwrite, go, pready, pslverr;
  logic        errv;
  logic [7:0]  paddr, nRsp;
  logic [31:0] pwdata, prdata, rdv;
  sld_req_s    loadReq, nextReq;
  sld_rsp_s    loadRsp, lastRsp;
  int          mismatches, n_tests, cycles, tokens;

  ////////////////////////////////////////////////////////////////////
  // fl: spec,ic,it,force,codepage,uncached,limited,impl; res: tok,flt,idx
  sld_row_s rows [34] = '{
    '{8'h00,8'h80,14'h0010,6'h20}, '{8'h00,8'h80,14'h0800,6'h20},
    '{8'h01,8'he8,14'h0010,6'h20}, '{8'h01,8'he8,14'h0008,6'h20},
    '{8'h00,8'he8,14'h0004,6'h12}, '{8'h00,8'he0,14'h0010,6'h14},
    '{8'h00,8'he0,14'h0002,6'h20}, '{8'h00,8'he0,14'h0012,6'h20},
    '{8'h00,8'he0,14'h0040,6'h20}, '{8'h00,8'he0,14'h0001,6'h20},
    '{8'h00,8'he0,14'h2000,6'h20}, '{8'h02,8'he8,14'h0820,6'h1b},
    '{8'h00,8'he8,14'h1000,6'h20}, '{8'h00,8'he0,14'h1000,6'h1c},
    '{8'h04,8'he8,14'h0080,6'h20}, '{8'h02,8'he8,14'h0020,6'h20},
    '{8'h08,8'he8,14'h0100,6'h20}, '{8'h10,8'he8,14'h0200,6'h20},
    '{8'h04,8'he8,14'h0100,6'h18}, '{8'h7f,8'hc8,14'h0400,6'h1a},
    '{8'h20,8'he8,14'h0400,6'h20}, '{8'h40,8'he8,14'h0800,6'h20},
    '{8'h04,8'he8,14'h0180,6'h20}, '{8'h00,8'he0,14'h0030,6'h14},
    '{8'h00,8'hf0,14'h0010,6'h20}, '{8'h00,8'hf0,14'h0000,6'h20},
    '{8'h00,8'he4,14'h0000,6'h20}, '{8'h00,8'he2,14'h0000,6'h20},
    '{8'h80,8'he9,14'h0000,6'h20}, '{8'h80,8'he1,14'h0000,6'h00},
    '{8'h00,8'he9,14'h0000,6'h00}, '{8'h00,8'he0,14'h0000,6'h00},
    '{8'h00,8'h40,14'h0010,6'h14}, '{8'h00,8'h50,14'h0000,6'h00}};

  sld_defer_unit sld_defer_unit_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loadReq(loadReq),
    .loadRsp(loadRsp));

  sld_pipe_model sld_pipe_model_inst (
    .clk(clk), .reset_n(reset_n), .go(go), .nextReq(nextReq),
    .lastRsp(lastRsp), .nRsp(nRsp), .loadReq(loadReq),
    .loadRsp(loadRsp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task chk_rsp(string nm, logic [6:0] e, logic [6:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // holds the request until pready is seen at a rising edge
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 10);
    if (k == 10) mismatches++;
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task load(sld_row_s r);
    logic [7:0] n;
    int         k;
    n = nRsp;
    @(posedge clk);
    nextReq <= {1'b1, r.fl, r.cond};
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (nRsp === n && k < 10) begin
      @(posedge clk);
      k++;
    end
    if (k == 10) mismatches++;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, psel, penable, pwrite, go} = 5'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    nextReq = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_reg("reset rsp", 32'h0, {22'h0, loadRsp});
    apb(1'b0, SLD_CTRL_ADDR, 32'h0);
    chk_reg("ctrl reset", 32'h0, rdv);
    apb(1'b1, SLD_CTRL_ADDR, 32'h85);
    apb(1'b0, SLD_CTRL_ADDR, 32'h0);
    chk_reg("ctrl rw", 32'h85, rdv);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, SLD_CTRL_ADDR, {24'h0, rows[i].ctrl});
      load(rows[i]);
      chk_rsp("outcome", {rows[i].res, rows[i].res[5:4] == 2'b00},
              {lastRsp.writeToken, lastRsp.fault, lastRsp.faultIdx,
               lastRsp.writeData});
      if (rows[i].res[4]) begin
        apb(1'b0, SLD_STAT_ADDR, 32'h0);
        chk_reg("status", {24'h0, rows[i].res[3:0], 2'b00, rows[i].fl[3],
                rows[i].fl[7]}, rdv & 32'hf3);
      end else begin
        chk_rsp("memory", {5'h0, rows[i].res[5], 1'b1},
                {5'h0, lastRsp.suppressMem, lastRsp.sideEffects});
      end
      tokens += rows[i].res[5];
      $display("test row %0d done", i);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk_reg("unmapped", 32'h1, {31'h0, errv});
    chk_reg("unmapped data", 32'h0, rdv);
    apb(1'b0, SLD_CNT_ADDR, 32'h0);
    chk_reg("token count", tokens, rdv);
    apb(1'b1, SLD_CTRL_ADDR, 32'h85);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, SLD_CTRL_ADDR, 32'h0);
    chk_reg("ctrl after reset", 32'h0, rdv);
    apb(1'b0, SLD_CNT_ADDR, 32'h0);
    chk_reg("count after reset", 32'h0, rdv);
    apb(1'b0, SLD_STAT_ADDR, 32'h0);
    chk_reg("status after reset", 32'h0, rdv);
    $display("test awkward done");
    report_and_stop;
  end
endmodule
